// [hdl/mafb_lane.sv]
module mafb_lane (
   // Operands in, product out
   mafb_lane_if.lane lif
);
   localparam int HW = mafb_pkg::HW;
   logic signed [2*HW-1:0] hi;
   logic signed [2*HW-1:0] lo;

   // One 18x18 multiplier or two independent 9x9 halves
   always_comb begin
      hi = $signed(lif.a[2*HW-1:HW]) * $signed(lif.b[2*HW-1:HW]);
      lo = $signed(lif.a[HW-1:0]) * $signed(lif.b[HW-1:0]);
      if (lif.m9) begin
         lif.p = {hi, lo};
      end else begin
         lif.p = lif.a * lif.b;
      end
   end
endmodule : mafb_lane

// [hdl/mafb_lane_if.sv]
interface mafb_lane_if;
   logic signed [mafb_pkg::DW-1:0] a;
   logic signed [mafb_pkg::DW-1:0] b;
   logic m9;
   logic [mafb_pkg::PW-1:0] p;
   modport host (output a, output b, output m9, input p);
   modport lane (input a, input b, input m9, output p);
endinterface : mafb_lane_if

// [hdl/mafb_pkg.sv]
package mafb_pkg;
   localparam int DW = 18;
   localparam int HW = DW / 2;
   localparam int LANES = 4;
   localparam int PW = 2 * DW;
   localparam int S2W = PW + 1;
   localparam int S4W = PW + $clog2(LANES);
   localparam int WW = 4 * DW;
   localparam int RW = LANES * PW;
   localparam int HRW = RW / 2;
   localparam int ACC_SW = 34;
   localparam int ACC_LW = 52;
   localparam int PAW = 12;
   localparam int LAT_W = 3;

   localparam logic [PAW-1:0] CTRL_OFS = 12'h000;
   localparam logic [PAW-1:0] STAT_OFS = 12'h004;
   localparam logic [PAW-1:0] CNT_OFS = 12'h008;

   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MODE_W = 3;
   localparam int CTRL_INREG_BIT = 4;
   localparam int CTRL_PIPE_BIT = 5;
   localparam int CTRL_OUTREG_BIT = 6;
   localparam int CTRL_CHAIN_BIT = 8;
   localparam int CTRL_ACCW_BIT = 9;
   localparam int CTRL_ACCCLR_BIT = 12;
   localparam logic [31:0] CTRL_MASK = 32'h0000_0377;
   localparam logic [31:0] CTRL_RST = 32'h0000_0175;

   localparam int STAT_LAT_LSB = 0;
   localparam int STAT_VLD_BIT = 4;

   typedef enum logic [CTRL_MODE_W-1:0] {
      MD_SIMPLE9,
      MD_SIMPLE18,
      MD_SIMPLE36,
      MD_MAC,
      MD_ADD2,
      MD_ADD4
   } mafb_mode_t;
endpackage : mafb_pkg

// [hdl/mafb_top.sv]
// Local design decisions: the placing of the registers and the APB register port.
module mafb_top (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [mafb_pkg::PAW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Sample and coefficient stream from fabric
   input wire logic in_vld_i,
   input wire logic addsub_i,
   input wire logic [mafb_pkg::WW-1:0] par_a_i,
   input wire logic [mafb_pkg::WW-1:0] coef_i,
   // Cascade chain to neighbour blocks
   input wire logic [mafb_pkg::DW-1:0] shift_in_i,
   output logic [mafb_pkg::DW-1:0] shift_out_o,
   // Result
   output logic [mafb_pkg::RW-1:0] res_o,
   output logic valid_o
);
   localparam int DW = mafb_pkg::DW;
   localparam int NL = mafb_pkg::LANES;
   localparam int PW = mafb_pkg::PW;
   localparam int S2W = mafb_pkg::S2W;
   localparam int S4W = mafb_pkg::S4W;
   localparam int RW = mafb_pkg::RW;
   localparam int HRW = mafb_pkg::HRW;
   localparam int AW = mafb_pkg::ACC_LW;
   localparam int ASW = mafb_pkg::ACC_SW;

   function automatic logic signed [S2W-1:0] add_sub(
      input logic signed [PW-1:0] x,
      input logic signed [PW-1:0] y,
      input logic sub
   );
      logic signed [S2W-1:0] xe;
      logic signed [S2W-1:0] ye;
      xe = S2W'(x);
      ye = S2W'(y);
      return sub ? xe - ye : xe + ye;
   endfunction : add_sub

   // Short variant wraps at 34 bits, then sign-extends to full width
   function automatic logic signed [AW-1:0] acc_wrap(
      input logic signed [AW-1:0] v,
      input logic lng
   );
      return lng ? v : AW'($signed(v[ASW-1:0]));
   endfunction : acc_wrap

   // Configuration
   logic [31:0] ctrl_r;
   logic [31:0] cnt_r;
   mafb_pkg::mafb_mode_t mode;
   logic in_en;
   logic pp_en;
   logic out_en;
   logic chain;
   logic acc_long;

   assign mode = mafb_pkg::mafb_mode_t'(
      ctrl_r[mafb_pkg::CTRL_MODE_LSB +: mafb_pkg::CTRL_MODE_W]);
   assign in_en = ctrl_r[mafb_pkg::CTRL_INREG_BIT];
   assign pp_en = ctrl_r[mafb_pkg::CTRL_PIPE_BIT];
   assign out_en = ctrl_r[mafb_pkg::CTRL_OUTREG_BIT];
   assign chain = ctrl_r[mafb_pkg::CTRL_CHAIN_BIT];
   assign acc_long = ctrl_r[mafb_pkg::CTRL_ACCW_BIT];

   // Datapath signals
   logic signed [DW-1:0] a_r [NL];
   logic signed [DW-1:0] b_r [NL];
   logic signed [DW-1:0] a_m [NL];
   logic signed [DW-1:0] b_m [NL];
   logic signed [PW-1:0] p_c [NL];
   logic signed [PW-1:0] p_r [NL];
   logic signed [PW-1:0] p_s [NL];
   logic signed [2*PW-1:0] w_c;
   logic signed [2*PW-1:0] w_r;
   logic signed [2*PW-1:0] w_s;
   logic signed [AW-1:0] acc_r [2];
   logic signed [S2W-1:0] s2 [2];
   logic signed [S4W-1:0] s4;
   logic [RW-1:0] res_c;
   logic [RW-1:0] res_r;
   logic sub_r;
   logic sub_m;
   logic sub_pr;
   logic sub_s;
   logic vin_r;
   logic vp_r;
   logic vacc_r;
   logic vo_r;
   logic v_in;
   logic v_pp;
   logic v_post;
   logic clr_acc;

   // Tap delay line: each load shifts one sample period down the chain
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < NL; i++) begin
            a_r[i] <= '0;
            b_r[i] <= '0;
         end
         sub_r <= 1'b0;
      end else if (in_vld_i) begin
         a_r[0] <= chain ? shift_in_i : par_a_i[0 +: DW];
         for (int i = 1; i < NL; i++) begin
            a_r[i] <= chain ? a_r[i-1] : par_a_i[i*DW +: DW];
         end
         for (int i = 0; i < NL; i++) begin
            b_r[i] <= coef_i[i*DW +: DW];
         end
         sub_r <= addsub_i;
      end
   end

   assign shift_out_o = a_r[NL-1];

   // Bypassed input stage feeds the multipliers straight from the pins
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         a_m[i] = in_en ? a_r[i] : par_a_i[i*DW +: DW];
         b_m[i] = in_en ? b_r[i] : coef_i[i*DW +: DW];
      end
      sub_m = in_en ? sub_r : addsub_i;
   end

   mafb_lane_if lif [NL] ();

   for (genvar g = 0; g < NL; g++) begin : g_lane
      assign lif[g].a = a_m[g];
      assign lif[g].b = b_m[g];
      assign lif[g].m9 = (mode == mafb_pkg::MD_SIMPLE9);
      assign p_c[g] = lif[g].p;
      mafb_lane u_lane (
         .lif (lif[g])
      );
   end

   // Wide mode reuses lanes 0 and 1 operands as the 18-bit halves of 36-bit operands
   assign w_c = $signed({a_m[1], a_m[0]}) * $signed({b_m[1], b_m[0]});

   // Pipeline stage after the multipliers
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < NL; i++) begin
            p_r[i] <= '0;
         end
         w_r <= '0;
         sub_pr <= 1'b0;
      end else begin
         p_r <= p_c;
         w_r <= w_c;
         sub_pr <= sub_m;
      end
   end

   always_comb begin
      for (int i = 0; i < NL; i++) begin
         p_s[i] = pp_en ? p_r[i] : p_c[i];
      end
      w_s = pp_en ? w_r : w_c;
      sub_s = pp_en ? sub_pr : sub_m;
   end

   // Adder tree with run-time add or subtract of odd products
   always_comb begin
      s2[0] = add_sub(p_s[0], p_s[1], sub_s);
      s2[1] = add_sub(p_s[2], p_s[3], sub_s);
      s4 = S4W'(s2[0]) + S4W'(s2[1]);
   end

   // Clear and accumulate in the same cycle restarts from this product
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         acc_r[0] <= '0;
         acc_r[1] <= '0;
      end else if (clr_acc || (mode == mafb_pkg::MD_MAC && v_pp)) begin
         for (int k = 0; k < 2; k++) begin
            if (mode == mafb_pkg::MD_MAC && v_pp) begin
               acc_r[k] <= acc_wrap((clr_acc ? AW'(0) : acc_r[k]) +
                  AW'(p_s[2*k]), acc_long);
            end else begin
               acc_r[k] <= '0;
            end
         end
      end
   end

   // Result routing per mode; illegal codes fall back to plain products
   always_comb begin
      unique case (mode)
         mafb_pkg::MD_SIMPLE9, mafb_pkg::MD_SIMPLE18: begin
            res_c = {p_s[3], p_s[2], p_s[1], p_s[0]};
         end
         mafb_pkg::MD_SIMPLE36: begin
            res_c = RW'(w_s);
         end
         mafb_pkg::MD_MAC: begin
            res_c = {HRW'(acc_r[1]), HRW'(acc_r[0])};
         end
         mafb_pkg::MD_ADD2: begin
            res_c = {HRW'(s2[1]), HRW'(s2[0])};
         end
         mafb_pkg::MD_ADD4: begin
            res_c = RW'(s4);
         end
         default: begin
            res_c = {p_s[3], p_s[2], p_s[1], p_s[0]};
         end
      endcase
   end

   // Valid follows the data through whichever stages are enabled
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         vin_r <= 1'b0;
         vp_r <= 1'b0;
         vacc_r <= 1'b0;
         vo_r <= 1'b0;
      end else begin
         vin_r <= in_vld_i;
         vp_r <= v_in;
         vacc_r <= (mode == mafb_pkg::MD_MAC) && v_pp;
         vo_r <= v_post;
      end
   end

   assign v_in = in_en ? vin_r : in_vld_i;
   assign v_pp = pp_en ? vp_r : v_in;
   assign v_post = (mode == mafb_pkg::MD_MAC) ? vacc_r : v_pp;

   // Output stage
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         res_r <= '0;
      end else begin
         res_r <= res_c;
      end
   end

   // Disabled output stage is a real bypass, so the port goes combinational
   assign res_o = out_en ? res_r : res_c;
   assign valid_o = out_en ? vo_r : v_post;

   // APB slave: one wait state, write lands on the pready edge
   logic acc_ph;
   logic hit;
   logic wr_fire;
   logic cnt_clr;
   logic pready_r;
   logic pslverr_r;
   logic [31:0] prdata_r;
   logic [31:0] rd_val;
   logic [31:0] status;
   logic [mafb_pkg::LAT_W-1:0] lat;

   assign acc_ph = psel_i && penable_i;
   assign wr_fire = acc_ph && pready_r && pwrite_i && hit;
   assign clr_acc = wr_fire && paddr_i == mafb_pkg::CTRL_OFS &&
      pwdata_i[mafb_pkg::CTRL_ACCCLR_BIT];
   assign cnt_clr = wr_fire && paddr_i == mafb_pkg::CNT_OFS;
   assign lat = mafb_pkg::LAT_W'(in_en) + mafb_pkg::LAT_W'(pp_en) +
      mafb_pkg::LAT_W'(out_en) +
      mafb_pkg::LAT_W'(mode == mafb_pkg::MD_MAC);

   always_comb begin
      status = 32'h0000_0000;
      status[mafb_pkg::STAT_LAT_LSB +: mafb_pkg::LAT_W] = lat;
      status[mafb_pkg::STAT_VLD_BIT] = valid_o;
   end

   always_comb begin
      hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (paddr_i)
         mafb_pkg::CTRL_OFS: rd_val = ctrl_r;
         mafb_pkg::STAT_OFS: rd_val = status;
         mafb_pkg::CNT_OFS: rd_val = cnt_r;
         default: hit = 1'b0;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else if (acc_ph && !pready_r) begin
         pready_r <= 1'b1;
         pslverr_r <= !hit;
         prdata_r <= rd_val;
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata_o = prdata_r;
   assign pready_o = pready_r;
   assign pslverr_o = pslverr_r;

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         ctrl_r <= mafb_pkg::CTRL_RST;
      end else if (wr_fire && paddr_i == mafb_pkg::CTRL_OFS) begin
         ctrl_r <= pwdata_i & mafb_pkg::CTRL_MASK;
      end
   end

   // Sample counter: a sample in the clearing cycle still counts
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         cnt_r <= 32'h0000_0000;
      end else if (cnt_clr) begin
         cnt_r <= {31'h0000_0000, in_vld_i};
      end else if (in_vld_i) begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   // Checks
   logic signed [AW-1:0] p0_ext;
   logic signed [S4W-1:0] chk4;
   logic all_en;

   assign p0_ext = AW'(p_s[0]);
   assign chk4 = S4W'(p_s[0]) + S4W'(p_s[1]) + S4W'(p_s[2]) + S4W'(p_s[3]);
   assign all_en = in_en && pp_en && out_en;

   a_chain_entry: assert property (@(posedge clock_i) disable iff (!rstn_i)
      in_vld_i && chain |=> a_r[0] == $past(shift_in_i))
      else $error("chain entry did not take shift input");
   a_tap_delay: assert property (@(posedge clock_i) disable iff (!rstn_i)
      in_vld_i && chain |=> a_r[2] == $past(a_r[1]))
      else $error("tap register did not shift by one sample");
   a_shift_out: assert property (@(posedge clock_i) disable iff (!rstn_i)
      in_vld_i && chain ##1 in_vld_i && chain
      |=> shift_out_o == $past(a_r[NL-3], 2))
      else $error("shift output not two samples behind lane one");
   a_par_load: assert property (@(posedge clock_i) disable iff (!rstn_i)
      in_vld_i && !chain |=> a_r[1] == $past(par_a_i[DW +: DW]))
      else $error("parallel load missed");
   a_valid_lat: assert property (@(posedge clock_i) disable iff (!rstn_i)
      in_vld_i && all_en && mode == mafb_pkg::MD_ADD4 && !wr_fire
      ##1 !wr_fire [*2] |=> valid_o)
      else $error("valid not three cycles after sample");
   a_reset_clear: assert property (@(posedge clock_i)
      !rstn_i |=> res_r == '0 && acc_r[0] == '0 && shift_out_o == '0)
      else $error("reset left a stage register set");
   a_acc_step: assert property (@(posedge clock_i) disable iff (!rstn_i)
      mode == mafb_pkg::MD_MAC && v_pp && !clr_acc && acc_long
      |=> acc_r[0] == $past(acc_r[0]) + $past(p0_ext))
      else $error("accumulator step wrong");
   a_acc_short: assert property (@(posedge clock_i) disable iff (!rstn_i)
      mode == mafb_pkg::MD_MAC && !acc_long
      |-> acc_r[1][AW-1:ASW-1] == '0 || &acc_r[1][AW-1:ASW-1])
      else $error("short accumulator not sign-extended");
   a_add4_sum: assert property (@(posedge clock_i) disable iff (!rstn_i)
      mode == mafb_pkg::MD_ADD4 && out_en && !sub_s && !wr_fire
      |=> res_o[S4W-1:0] == $past(chk4))
      else $error("four product sum wrong");
   a_simple_out: assert property (@(posedge clock_i) disable iff (!rstn_i)
      mode == mafb_pkg::MD_SIMPLE18 && out_en && !wr_fire
      |=> res_o[2*PW-1:PW] == $past(p_s[1]))
      else $error("simple product not on own output");
   a_apb_wait: assert property (@(posedge clock_i) disable iff (!rstn_i)
      acc_ph && !pready_r |=> pready_o ##1 !pready_o)
      else $error("APB answer not one wait state");

   c_mac_run: cover property (@(posedge clock_i) disable iff (!rstn_i)
      mode == mafb_pkg::MD_MAC && vacc_r ##1 vacc_r);
   c_fir_out: cover property (@(posedge clock_i) disable iff (!rstn_i)
      mode == mafb_pkg::MD_ADD4 && chain && valid_o);
   c_sub_add2: cover property (@(posedge clock_i) disable iff (!rstn_i)
      mode == mafb_pkg::MD_ADD2 && sub_s && valid_o);
endmodule : mafb_top

// [tb/mafb_upstream.sv]
module mafb_upstream (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rstn_i,
   // Sample strobe, value and coefficients from fabric
   input wire logic vld_i,
   input wire logic [mafb_pkg::DW-1:0] x_i,
   input wire logic [mafb_pkg::WW-1:0] coef_i,
   // Cascade output to next block
   output logic [mafb_pkg::DW-1:0] shift_out_o,
   // Four-tap partial sum for the fabric adder
   output logic signed [mafb_pkg::S4W-1:0] part_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [mafb_pkg::DW-1:0] tap_r [4];
   logic signed [mafb_pkg::DW-1:0] h_r [4];
   logic signed [mafb_pkg::S4W-1:0] sum_c;
   logic signed [mafb_pkg::S4W-1:0] sum_r;
   logic signed [mafb_pkg::S4W-1:0] part_r;

   // Previous block in the column, shift chain only
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         tap_r <= '{default: '0};
         h_r <= '{default: '0};
      end else if (vld_i) begin
         tap_r[0] <= x_i;
         for (int i = 1; i < 4; i++) begin
            tap_r[i] <= tap_r[i-1];
         end
         for (int i = 0; i < 4; i++) begin
            h_r[i] <= coef_i[i*mafb_pkg::DW +: mafb_pkg::DW];
         end
      end
   end
   assign shift_out_o = tap_r[3];

   always_comb begin
      sum_c = '0;
      for (int i = 0; i < 4; i++) begin
         sum_c = sum_c + $signed(tap_r[i]) * h_r[i];
      end
   end

   // Two stages so the sum lines up with a fully registered neighbour
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         sum_r <= '0;
         part_r <= '0;
      end else begin
         sum_r <= sum_c;
         part_r <= sum_r;
      end
   end
   assign part_o = part_r;
endmodule : mafb_upstream

// [tb/tb_multiply_add_fir_block.sv]
module tb_multiply_add_fir_block;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i = 1'b0;
   logic rstn_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [mafb_pkg::PAW-1:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, valid_o, in_vld = 1'b0, addsub = 1'b0;
   logic [mafb_pkg::WW-1:0] par_a = '0, coef = '0, up_coef = '0;
   logic signed [mafb_pkg::S4W-1:0] up_part;
   logic signed [17:0] hist [8];
   logic [mafb_pkg::DW-1:0] up_x = '0, shift_in, shift_out;
   logic [mafb_pkg::RW-1:0] res;
   int mismatches = 0, n_compared = 0, cyc = 0, md, lat, nsamp = 0;
   logic chain, w52;
   logic [31:0] seed = 32'hCF12C696;
   logic signed [17:0] ar [4], br [4], pq [4];
   logic signed [51:0] acc0, acc1;
   logic [143:0] exp_q [$];
   int cyc_q [$];
   logic [143:0] y8_q [$];
   bit f8_q [$];

   always #5 clock_i = ~clock_i;

   mafb_upstream UP (.clock_i(clock_i), .rstn_i(rstn_i), .vld_i(in_vld),
      .x_i(up_x), .coef_i(up_coef), .shift_out_o(shift_in),
      .part_o(up_part));

   mafb_top DUT (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .in_vld_i(in_vld), .addsub_i(addsub),
      .par_a_i(par_a), .coef_i(coef), .shift_in_i(shift_in),
      .shift_out_o(shift_out), .res_o(res), .valid_o(valid_o));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   task automatic chk_res(input logic [143:0] g, input logic [143:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_res

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk_reg

   task automatic tally_and_finish;
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // Results are matched in order; the cycle check pins the latency
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (rstn_i && valid_o === 1'b1) begin
         if (exp_q.size() == 0) chk_reg(32'h1, 32'h0);
         else begin
            chk_res(res, exp_q.pop_front());
            chk_reg(cyc, cyc_q.pop_front());
            // Fabric adder: this block plus the previous four taps
            if (f8_q.pop_front())
               chk_res($signed(res) + up_part, y8_q.pop_front());
         end
      end
      if (cyc > 20000) begin
         mismatches++;
         tally_and_finish;
      end
   end

   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      do @(posedge clock_i); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [11:0] a, input logic [31:0] ev,
         input logic ee);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      chk_reg(q, ev);
      chk_reg({31'h0, e}, {31'h0, ee});
   endtask : rd

   task automatic wr(input logic [11:0] a, input logic [31:0] d,
         input logic ee);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
      chk_reg({31'h0, e}, {31'h0, ee});
   endtask : wr

   task automatic setcfg(input logic [31:0] c);
      wr(12'h000, c, 1'b0);
      md = c[2:0];
      chain = c[8];
      w52 = c[9];
      lat = c[4] + c[5] + c[6] + (md == 3);
      if (c[12]) begin
         acc0 = '0;
         acc1 = '0;
      end
   endtask : setcfg

   function automatic logic [143:0] model(logic sub);
      logic signed [143:0] r;
      logic signed [71:0] p [4];
      r = '0;
      for (int i = 0; i < 4; i++) p[i] = ar[i] * br[i];
      case (md)
         0: for (int i = 0; i < 4; i++) begin
            r[36*i+18 +: 18] = $signed(ar[i][17:9]) * $signed(br[i][17:9]);
            r[36*i +: 18] = $signed(ar[i][8:0]) * $signed(br[i][8:0]);
         end
         2: r = $signed({ar[1], ar[0]}) * $signed({br[1], br[0]});
         3: begin
            acc0 = acc0 + p[0];
            acc1 = acc1 + p[2];
            if (!w52) begin
               acc0 = $signed(acc0[33:0]);
               acc1 = $signed(acc1[33:0]);
            end
            r = {{20{acc1[51]}}, acc1, {20{acc0[51]}}, acc0};
         end
         4: begin
            r[71:0] = sub ? p[0] - p[1] : p[0] + p[1];
            r[143:72] = sub ? p[2] - p[3] : p[2] + p[3];
         end
         5: r = (sub ? p[0] - p[1] : p[0] + p[1])
               + (sub ? p[2] - p[3] : p[2] + p[3]);
         default: for (int i = 0; i < 4; i++) r[36*i +: 36] = p[i][35:0];
      endcase
      return r;
   endfunction : model

   // Back-to-back samples, random data, operand halves and add/sub
   task automatic send(input int n);
      logic [95:0] ta, tb, tu;
      logic [31:0] tx;
      logic signed [143:0] y8;
      bit f8;
      repeat (n) begin
         ta = {rnd(), rnd(), rnd()};
         tb = {rnd(), rnd(), rnd()};
         tu = {rnd(), rnd(), rnd()};
         tx = rnd();
         @(posedge clock_i);
         in_vld <= 1'b1;
         par_a <= ta[71:0];
         coef <= tb[71:0];
         up_coef <= tu[71:0];
         addsub <= tx[31];
         up_x <= tx[17:0];
         for (int i = 3; i > 0; i--) ar[i] = chain ? ar[i-1] : ta[18*i +: 18];
         ar[0] = chain ? pq[3] : ta[17:0];
         for (int i = 3; i > 0; i--) pq[i] = pq[i-1];
         pq[0] = tx[17:0];
         for (int i = 0; i < 4; i++) br[i] = tb[18*i +: 18];
         // Direct eight-tap sum from the sample history
         for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
         hist[0] = tx[17:0];
         y8 = '0;
         for (int i = 0; i < 4; i++) begin
            y8 = y8 + hist[i] * $signed(tu[18*i +: 18])
               + hist[i+4] * $signed(tb[18*i +: 18]);
         end
         f8 = chain && md == 5 && lat == 3 && !tx[31];
         if (f8) y8_q.push_back(y8);
         f8_q.push_back(f8);
         exp_q.push_back(model(tx[31]));
         cyc_q.push_back(cyc + 1 + lat);
         nsamp++;
      end
   endtask : send

   task automatic flush;
      @(posedge clock_i);
      in_vld <= 1'b0;
      repeat (8) @(posedge clock_i);
      chk_reg(exp_q.size(), 32'h0);
      if (chain) chk_reg({14'h0, shift_out}, {14'h0, ar[3]});
   endtask : flush

   task automatic clr_model;
      acc0 = '0;
      acc1 = '0;
      for (int i = 0; i < 4; i++) begin
         ar[i] = '0;
         pq[i] = '0;
      end
      for (int i = 0; i < 8; i++) hist[i] = '0;
   endtask : clr_model

   initial begin
      clr_model;
      repeat (16) @(posedge clock_i);
      rstn_i <= 1'b1;
      rd(12'h000, 32'h175, 1'b0);
      rd(12'h004, 32'h003, 1'b0);
      rd(12'h008, 32'h000, 1'b0);
      wr(12'h00C, 32'h5, 1'b1);
      rd(12'h00C, 32'h0, 1'b1);
      wr(12'h004, 32'hFF, 1'b0);
      rd(12'h004, 32'h003, 1'b0);
      setcfg(32'hFFFFFFFF);
      rd(12'h000, 32'h377, 1'b0);
      setcfg(32'h175);
      wr(12'h008, 32'h0, 1'b0);
      nsamp = 0;
      send(20);
      flush;
      rd(12'h008, nsamp, 1'b0);
      wr(12'h008, 32'h0, 1'b0);
      rd(12'h008, 32'h0, 1'b0);
      // Every mode code except MAC (3), parallel load, all stages on
      for (int m = 0; m < 8; m++) begin
         if (m != 3) begin
            setcfg(32'h270 | m);
            send(12);
            flush;
         end
      end
      // Accumulators, both widths; the 34-bit one wraps
      for (int w = 0; w < 2; w++) begin
         setcfg(32'h1073 | (w << 9));
         send(30);
         flush;
      end
      @(posedge clock_i);
      rstn_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rstn_i <= 1'b1;
      clr_model;
      rd(12'h000, 32'h175, 1'b0);
      rd(12'h008, 32'h0, 1'b0);
      setcfg(32'h373);
      send(10);
      flush;
      // All eight stage combinations, latency from 0 to 3
      for (int s = 0; s < 8; s++) begin
         setcfg(32'h205 | (s << 4));
         rd(12'h004, lat, 1'b0);
         send(10);
         flush;
      end
      tally_and_finish;
   end
endmodule : tb_multiply_add_fir_block
